//--- itsa_core.sv
// two-wire serial target of the interval timer: setting register, seconds
// counter, timer clear command and oscillation start control
// assumes scl, sda and the output-control pin are raw pins and that
// second_tick_i is a one-cycle pulse from logic on the same clock
//
// Overview of operation
// - Transfers open with start and address 0110010; other addresses are ignored.
// - Setting field comes from whole third byte and fourth byte bits 7..5.
// - Second byte bits 6..1 and fourth byte bits 4..3 are don't care.
// - Fourth byte bits 2..0 equal to 010 clear the timer; others do not.
// - Setting read needs dummy write with pointer bit zero, then restart read.
// - Output-control pin low during a read returns the time register.
// - Read bytes leave msb first; controller ends with not-acknowledge and stop.
// - Reading past the register's bytes returns all-ones bytes.
// - Stop clears the address pointer, so later reads return the time register.
// - Output-control pin never resets the interface; only stop returns to idle.
// - While the target drives sda low, start and stop are not detected.
// - Powered up with pin low, oscillation start high; dropped after pin goes high.
// - Powered up with pin high, pin low for 500 ms raises oscillation start.
// - Timer clear zeroes the 24-bit seconds counter, which keeps counting.
// - Timer clear leaves the stored setting unchanged.
`default_nettype none
module itsa_core #(
   parameter int unsigned OSC_LOW_CYCLES = itsa_pkg::OSC_LOW_CYCLES
) (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   input wire logic output_control_pin_i,
   input wire logic second_tick_i,
   output logic [itsa_pkg::SET_FIELD_W-1:0] setting_o,
   output logic [2:0] timer_clear_code_o,
   output logic [23:0] seconds_o,
   output logic timer_clear_o,
   output logic osc_start_o
);
   ////////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      itsa_pkg::itsa_state_type st;
      logic scl_p;
      logic sda_p;
      logic [3:0] bit_cnt;
      logic [7:0] shift;
      logic [2:0] byte_idx;
      logic [2:0] rd_idx;
      logic rd_mode;
      logic ptr_setting;
      logic drive_low;
      logic [15:0] setting;
      logic [23:0] seconds;
      logic clear_pulse;
      logic [1:0] boot_cnt;
      logic osc_start;
      logic [itsa_pkg::OSC_CNT_W-1:0] low_cnt;
   } itsa_core_type;

   itsa_core_type r_q;
   itsa_core_type r_d;
   logic [2:0] pins_s;
   logic scl_s;
   logic sda_s;
   logic pin_s;

   itsa_sync #(
      .WIDTH(3)
   ) u_sync (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .ce_i(ce_i),
      .async_i({scl_i, sda_i, output_control_pin_i}),
      .sync_o(pins_s)
   );
   assign scl_s = pins_s[2];
   assign sda_s = pins_s[1];
   assign pin_s = pins_s[0];

   ////////////////////////////////////////////////////////////////////////////
   // byte presented to the controller for read position idx
   function automatic logic [7:0] read_byte(input logic [2:0] idx, input logic ptr_set,
                                            input logic pin_hi, input logic [15:0] set,
                                            input logic [23:0] secs);
      logic [7:0] b;
      b = itsa_pkg::IDLE_BYTE;
      if (ptr_set && pin_hi) begin
         if (idx == 3'h0) begin
            b = set[15:8];
         end else if (idx == 3'h1) begin
            b = set[7:0];
         end
      end else begin
         if (idx == 3'h0) begin
            b = secs[23:16];
         end else if (idx == 3'h1) begin
            b = secs[15:8];
         end else if (idx == 3'h2) begin
            b = secs[7:0];
         end
      end
      return b;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   logic scl_rise;
   logic scl_fall;
   logic start_seen;
   logic stop_seen;
   logic [7:0] rx_byte;
   logic [7:0] tx_byte;

   always_comb begin
      r_d = r_q;
      scl_rise = scl_s & ~r_q.scl_p;
      scl_fall = ~scl_s & r_q.scl_p;
      // blind to start and stop while our own driver holds sda low
      start_seen = scl_s & r_q.scl_p & r_q.sda_p & ~sda_s & ~r_q.drive_low;
      stop_seen = scl_s & r_q.scl_p & ~r_q.sda_p & sda_s & ~r_q.drive_low;
      rx_byte = r_q.shift;
      tx_byte = read_byte(r_q.rd_idx, r_q.ptr_setting, pin_s, r_q.setting, r_q.seconds);
      r_d.scl_p = scl_s;
      r_d.sda_p = sda_s;
      r_d.clear_pulse = 1'b0;

      // seconds counter saturates at its top value
      if (second_tick_i && r_q.seconds != itsa_pkg::SECONDS_MAX) begin
         r_d.seconds = r_q.seconds + 24'h00_0001;
      end

      // interface sequencer; the output-control pin reaches it only through tx_byte
      if (stop_seen) begin
         r_d.st = itsa_pkg::ST_IDLE;
         r_d.ptr_setting = 1'b0;
         r_d.drive_low = 1'b0;
      end else if (start_seen) begin
         r_d.st = itsa_pkg::ST_RX;
         r_d.bit_cnt = 4'h0;
         r_d.byte_idx = 3'h0;
         r_d.rd_idx = 3'h0;
      end else begin
         unique case (r_q.st)
            itsa_pkg::ST_IDLE, itsa_pkg::ST_WAIT: begin
            end
            itsa_pkg::ST_RX: begin
               if (scl_rise && r_q.bit_cnt < 4'(itsa_pkg::BITS_PER_BYTE)) begin
                  r_d.shift = {r_q.shift[6:0], sda_s};
                  r_d.bit_cnt = r_q.bit_cnt + 4'h1;
               end else if (scl_fall && r_q.bit_cnt == 4'(itsa_pkg::BITS_PER_BYTE)) begin
                  if (r_q.byte_idx == 3'h0 && rx_byte[7:1] != itsa_pkg::TARGET_ADDR) begin
                     r_d.st = itsa_pkg::ST_WAIT;
                  end else begin
                     r_d.st = itsa_pkg::ST_RX_ACK;
                     r_d.drive_low = 1'b1;
                     if (r_q.byte_idx == 3'h0) begin
                        r_d.rd_mode = rx_byte[itsa_pkg::RW_BIT];
                     end
                  end
               end
            end
            itsa_pkg::ST_RX_ACK: begin
               if (scl_fall) begin
                  r_d.drive_low = 1'b0;
                  r_d.bit_cnt = 4'h0;
                  r_d.st = itsa_pkg::ST_RX;
                  if (r_q.byte_idx != itsa_pkg::IDX_MAX) begin
                     r_d.byte_idx = r_q.byte_idx + 3'h1;
                  end
                  // commit after the acknowledge clock has ended
                  if (r_q.byte_idx == 3'h0 && r_q.rd_mode) begin
                     r_d.st = itsa_pkg::ST_TX;
                     r_d.shift = tx_byte;
                     r_d.drive_low = ~tx_byte[7];
                     r_d.bit_cnt = 4'h1;
                  end else if (r_q.byte_idx == itsa_pkg::IDX_POINTER) begin
                     // test bit and bits 6..1 carry no function here
                     r_d.ptr_setting = ~rx_byte[itsa_pkg::POINTER_BIT];
                  end else if (r_q.byte_idx == itsa_pkg::IDX_SET_HI) begin
                     r_d.setting[15:8] = rx_byte;
                  end else if (r_q.byte_idx == itsa_pkg::IDX_SET_LO) begin
                     // bits 4..3 are stored only so a read returns them
                     r_d.setting[7:0] = rx_byte;
                     if (rx_byte[2:0] == itsa_pkg::TIMER_CLEAR_CODE) begin
                        r_d.seconds = 24'h00_0000;
                        r_d.clear_pulse = 1'b1;
                     end
                  end
               end
            end
            itsa_pkg::ST_TX: begin
               if (scl_fall) begin
                  if (r_q.bit_cnt == 4'(itsa_pkg::BITS_PER_BYTE)) begin
                     r_d.drive_low = 1'b0;
                     r_d.st = itsa_pkg::ST_TX_ACK;
                  end else begin
                     r_d.shift = {r_q.shift[6:0], 1'b1};
                     r_d.drive_low = ~r_q.shift[6];
                     r_d.bit_cnt = r_q.bit_cnt + 4'h1;
                  end
               end
            end
            itsa_pkg::ST_TX_ACK: begin
               if (scl_rise) begin
                  if (sda_s) begin
                     r_d.st = itsa_pkg::ST_WAIT;
                  end else if (r_q.rd_idx != itsa_pkg::IDX_MAX) begin
                     r_d.rd_idx = r_q.rd_idx + 3'h1;
                  end
               end else if (scl_fall) begin
                  r_d.st = itsa_pkg::ST_TX;
                  r_d.shift = tx_byte;
                  r_d.drive_low = ~tx_byte[7];
                  r_d.bit_cnt = 4'h1;
               end
            end
            default: begin
               r_d.st = itsa_pkg::ST_IDLE;
               r_d.drive_low = 1'b0;
            end
         endcase
      end

      // oscillation start: pin level caught once the synchroniser has filled;
      // its reset value of ones would otherwise hide a pin held low at power-up
      if (r_q.boot_cnt != 2'h3) begin
         r_d.boot_cnt = r_q.boot_cnt + 2'h1;
         r_d.osc_start = ~pin_s;
         r_d.low_cnt = '0;
      end else if (pin_s) begin
         r_d.osc_start = 1'b0;
         r_d.low_cnt = '0;
      end else if (r_q.osc_start) begin
         r_d.low_cnt = '0;
      end else if (r_q.low_cnt >= itsa_pkg::OSC_CNT_W'(OSC_LOW_CYCLES - 1)) begin
         r_d.osc_start = 1'b1;
      end else begin
         r_d.low_cnt = r_q.low_cnt + itsa_pkg::OSC_CNT_W'(1);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         r_q <= '{st: itsa_pkg::ST_IDLE, scl_p: 1'b1, sda_p: 1'b1, bit_cnt: 4'h0,
                  shift: 8'h00, byte_idx: 3'h0, rd_idx: 3'h0, rd_mode: 1'b0,
                  ptr_setting: 1'b0, drive_low: 1'b0,
                  setting: itsa_pkg::SETTING_RESET, seconds: 24'h00_0000,
                  clear_pulse: 1'b0, boot_cnt: 2'h0, osc_start: 1'b0,
                  low_cnt: '0};
      end else if (ce_i) begin
         r_q <= r_d;
      end
   end

   assign sda_o = 1'b0;
   assign sda_oe_o = r_q.drive_low;
   assign setting_o = r_q.setting[15:itsa_pkg::SET_FIELD_LSB];
   assign timer_clear_code_o = r_q.setting[2:0];
   assign seconds_o = r_q.seconds;
   assign timer_clear_o = r_q.clear_pulse;
   assign osc_start_o = r_q.osc_start;
endmodule
`default_nettype wire

//--- itsa_core_assertions.sv
// checker for the interval timer two-wire target, on itsa_core ports
// assumes one clock domain; bound to itsa_core below
`default_nettype none
module itsa_core_assertions #(
   parameter int unsigned OSC_LOW_CYCLES = 20
) (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe_o,
   input wire logic output_control_pin_i,
   input wire logic second_tick_i,
   input wire logic [itsa_pkg::SET_FIELD_W-1:0] setting_o,
   input wire logic [2:0] timer_clear_code_o,
   input wire logic [23:0] seconds_o,
   input wire logic timer_clear_o,
   input wire logic osc_start_o
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   logic [31:0] low_cnt_q;
   // counts enabled cycles with the pin low; saturates rather than wraps
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         low_cnt_q <= 32'h0000_0000;
      end else if (output_control_pin_i) begin
         low_cnt_q <= 32'h0000_0000;
      end else if (ce_i && low_cnt_q != 32'hFFFF_FFFF) begin
         low_cnt_q <= low_cnt_q + 32'h0000_0001;
      end
   end
   sequence s_tick;
      ce_i && second_tick_i && seconds_o != itsa_pkg::SECONDS_MAX;
   endsequence
   sequence s_pin_high;
      (ce_i && output_control_pin_i)[*6];
   endsequence
   a_sda_only_low: assert property (sda_o == 1'b0)
      else $error("data pin driven high");
   a_clear_zeroes_count: assert property (timer_clear_o |-> seconds_o == 24'h00_0000)
      else $error("clear left seconds nonzero");
   a_clear_code_match: assert property (timer_clear_o |->
      timer_clear_code_o == itsa_pkg::TIMER_CLEAR_CODE)
      else $error("clear with wrong code");
   a_other_code_keeps: assert property ($changed(timer_clear_code_o) &&
      timer_clear_code_o != itsa_pkg::TIMER_CLEAR_CODE |-> !timer_clear_o)
      else $error("clear on other code");
   a_tick_increments: assert property (s_tick |=>
      timer_clear_o || seconds_o == $past(seconds_o) + 24'h00_0001)
      else $error("tick did not count");
   a_seconds_hold: assert property (ce_i && !second_tick_i |=>
      timer_clear_o || $stable(seconds_o))
      else $error("seconds moved without tick");
   a_osc_drop_high: assert property (s_pin_high |-> !osc_start_o)
      else $error("oscillation start kept with pin high");
   a_osc_rise_low: assert property (low_cnt_q == OSC_LOW_CYCLES + 8 |-> osc_start_o)
      else $error("oscillation start missing after long low");
endmodule
bind itsa_core itsa_core_assertions #(.OSC_LOW_CYCLES(OSC_LOW_CYCLES)) i_itsa_core_assertions (
   .clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .scl_i(scl_i), .sda_i(sda_i),
   .sda_o(sda_o), .sda_oe_o(sda_oe_o), .output_control_pin_i(output_control_pin_i),
   .second_tick_i(second_tick_i), .setting_o(setting_o),
   .timer_clear_code_o(timer_clear_code_o), .seconds_o(seconds_o),
   .timer_clear_o(timer_clear_o), .osc_start_o(osc_start_o));
`default_nettype wire

//--- itsa_core_tb.sv
// self-checking bench for itsa_core with a bus controller model
// assumes the checker is bound from its own file
`default_nettype none
module itsa_core_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic pin = 1'b1;
   logic tick = 1'b0;
   logic scl, sda_c, sda_oe, sda_do, res_stb, clr, osc, dummy;
   logic [8:0] res;
   logic [10:0] setting;
   logic [2:0] code;
   logic [23:0] secs;
   logic [23:0] exp_secs = 24'h00_0000;
   logic [15:0] lfsr = 16'hADB5;
   logic [7:0] b3, b4;
   wire logic sda_w;
   int error_cnt = 0;
   int tests_run = 0;
   int clr_cnt = 0;
   logic [8:0] exp_q[$];
   assign sda_w = sda_c & (~sda_oe | sda_do);
   always #5 clk = ~clk;
   // clear pulses counted away from the edge that launches them
   always @(negedge clk) begin
      if (clr === 1'b1) begin
         clr_cnt++;
      end
   end
   itsa_core #(.OSC_LOW_CYCLES(20)) i_itsa_core (.clock_i(clk), .rst_n_i(rst_n), .ce_i(1'b1),
      .scl_i(scl), .sda_i(sda_w), .sda_o(sda_do), .sda_oe_o(sda_oe),
      .output_control_pin_i(pin), .second_tick_i(tick), .setting_o(setting),
      .timer_clear_code_o(code), .seconds_o(secs), .timer_clear_o(clr), .osc_start_o(osc));
   itsa_ctrl_model i_itsa_ctrl_model (.sda_i(sda_w), .scl_o(scl), .sda_o(sda_c),
      .res_stb_o(res_stb), .res_o(res));
   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d, mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   always @(posedge res_stb) begin
      if (exp_q.size() == 0) check(24'h00_0000, 24'h00_0001);
      else check({15'h0000, res}, {15'h0000, exp_q.pop_front()});
   end
   task automatic xb(input logic [7:0] b, input logic ack, input logic [8:0] e);
      exp_q.push_back(e);
      i_itsa_ctrl_model.xfer(b, ack);
   endtask
   task automatic write_set(input logic [7:0] h, input logic [7:0] l);
      i_itsa_ctrl_model.start();
      xb(8'h64, 1'b1, 9'h0C8);
      xb(8'h7F, 1'b1, 9'h0FE);
      xb(h, 1'b1, {h, 1'b0});
      xb(l, 1'b1, {l, 1'b0});
      i_itsa_ctrl_model.stop();
   endtask
   // three read bytes, the last one refused; ptr asks for the dummy write first
   task automatic read3(input logic ptr, input logic [23:0] e);
      i_itsa_ctrl_model.start();
      if (ptr) begin
         xb(8'h64, 1'b1, 9'h0C8);
         xb(8'h01, 1'b1, 9'h002);
         i_itsa_ctrl_model.start();
      end
      xb(8'h65, 1'b1, 9'h0CA);
      xb(8'hFF, 1'b0, {e[23:16], 1'b0});
      xb(8'hFF, 1'b0, {e[15:8], 1'b0});
      xb(8'hFF, 1'b1, {e[7:0], 1'b1});
      i_itsa_ctrl_model.stop();
   endtask
   function automatic logic [15:0] lfsr_next(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   task automatic ticks(input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         #1;
         lfsr = lfsr_next(lfsr);
         tick = lfsr[0];
         exp_secs += 24'(lfsr[0]);
      end
      @(posedge clk);
      #1 tick = 1'b0;
   endtask
   initial begin
      repeat (100000) @(posedge clk);
      error_cnt++;
      tally_and_finish();
   end
   initial begin
      repeat (5) @(posedge clk);
      #1 rst_n = 1'b1;
      repeat (5) @(posedge clk);
      #1;
      check({osc, setting, code}, 24'h00_0000);
      i_itsa_ctrl_model.start();
      xb(8'h66, 1'b1, 9'h0CD);
      i_itsa_ctrl_model.stop();
      for (int c = 0; c < 8; c++) begin
         ticks(6);
         b3 = lfsr[15:8];
         b4 = {lfsr[7:3], 3'(c)};
         write_set(b3, b4);
         if (c == 2) exp_secs = 24'h00_0000;
         check(secs, exp_secs);
         check({setting, code}, {10'h000, b3, b4[7:5], b4[2:0]});
      end
      ticks(20);
      check(secs, exp_secs);
      read3(1'b0, exp_secs);
      read3(1'b1, {b3, b4, 8'hFF});
      @(posedge clk);
      #1 pin = 1'b0;
      read3(1'b1, exp_secs);
      check(osc, 1'b1);
      @(posedge clk);
      #1 pin = 1'b1;
      repeat (10) @(posedge clk);
      check(osc, 1'b0);
      // leave the target driving a read bit, then recover the bus
      i_itsa_ctrl_model.start();
      xb(8'h65, 1'b1, 9'h0CA);
      for (int i = 0; i < 3; i++) i_itsa_ctrl_model.bit_xfer(1'b1, dummy);
      i_itsa_ctrl_model.start();
      for (int i = 0; i < 9; i++) i_itsa_ctrl_model.bit_xfer(1'b1, dummy);
      i_itsa_ctrl_model.stop();
      write_set(8'hA5, 8'h47);
      check({setting, code}, {10'h000, 8'hA5, 3'h2, 3'h7});
      check(24'(exp_q.size()), 24'h00_0000);
      check(24'(clr_cnt), 24'h00_0001);
      // second reset with the pin held low: start must rise at power-up capture
      @(posedge clk);
      #1 pin = 1'b0;
      rst_n = 1'b0;
      repeat (2) @(posedge clk);
      #1 rst_n = 1'b1;
      repeat (6) @(posedge clk);
      #1;
      check(osc, 1'b1);
      check({setting, code}, 24'h00_0000);
      check(secs, 24'h00_0000);
      tally_and_finish();
   end
endmodule
`default_nettype wire

//--- itsa_ctrl_model.sv
// two-wire bus controller model: start, stop and nine-clock byte transfers
// assumes the bench resolves the pulled-up data wire into sda_i
`default_nettype none
module itsa_ctrl_model (
   input wire logic sda_i,
   output logic scl_o,
   output logic sda_o,
   output logic res_stb_o,
   output logic [8:0] res_o
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
      res_stb_o = 1'b0;
      res_o = 9'h000;
   end
   // 40 ns low then 40 ns high; data moves only while the clock is low
   task automatic bit_xfer(input logic b, output logic s);
      #10 sda_o = b;
      #30 scl_o = 1'b1;
      #38 s = sda_i;
      #2 scl_o = 1'b0;
   endtask
   // doubles as repeated start when entered with the clock low
   task automatic start();
      if (!scl_o) begin
         #10 sda_o = 1'b1;
         #30 scl_o = 1'b1;
      end
      #40 sda_o = 1'b0;
      #40 scl_o = 1'b0;
   endtask
   task automatic stop();
      #10 sda_o = 1'b0;
      #30 scl_o = 1'b1;
      #40 sda_o = 1'b1;
      #40;
   endtask
   // result is the wire as sampled: eight bits msb first, then the acknowledge
   task automatic xfer(input logic [7:0] wr, input logic ack);
      logic [8:0] v;
      logic [8:0] w;
      v = {wr, ack};
      for (int i = 8; i >= 0; i--) begin
         bit_xfer(v[i], w[i]);
      end
      res_o = w;
      // strobe drops without holding the caller, so the link timing stays put
      res_stb_o = 1'b1;
      res_stb_o <= #1 1'b0;
   endtask
endmodule
`default_nettype wire

//--- itsa_pkg.sv
// shared constants for the interval timer two-wire serial access block
// assumes a 100 MHz system clock and a two-wire bus sampled as plain pins
`default_nettype none
package itsa_pkg;
   localparam int unsigned CLK_HZ = 100_000_000;
   // oscillation start hold time, in milliseconds
   localparam int unsigned OSC_LOW_MS = 500;
   localparam int unsigned OSC_LOW_CYCLES = OSC_LOW_MS * (CLK_HZ / 1000);
   localparam int unsigned OSC_CNT_W = 26;

   localparam logic [6:0] TARGET_ADDR = 7'h32;
   localparam logic [2:0] TIMER_CLEAR_CODE = 3'h2;
   localparam logic [15:0] SETTING_RESET = 16'h0000;
   localparam logic [23:0] SECONDS_MAX = 24'hFF_FFFF;
   localparam logic [7:0] IDLE_BYTE = 8'hFF;

   // field positions inside the stored setting word and the received bytes
   localparam int unsigned SET_FIELD_LSB = 5;
   localparam int unsigned SET_FIELD_W = 11;
   localparam int unsigned POINTER_BIT = 7;
   localparam int unsigned RW_BIT = 0;
   localparam int unsigned BITS_PER_BYTE = 8;

   // byte positions within a transfer, address byte is 0
   localparam logic [2:0] IDX_POINTER = 3'h1;
   localparam logic [2:0] IDX_SET_HI = 3'h2;
   localparam logic [2:0] IDX_SET_LO = 3'h3;
   localparam logic [2:0] IDX_MAX = 3'h7;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_RX = 3'b001,
      ST_RX_ACK = 3'b010,
      ST_TX = 3'b011,
      ST_TX_ACK = 3'b100,
      ST_WAIT = 3'b101
   } itsa_state_type;
endpackage
`default_nettype wire

//--- itsa_sync.sv
// two flip-flop synchroniser for pins from outside the clock domain
// assumes the clock enable freezes it together with the rest of the block
`default_nettype none
module itsa_sync #(
   parameter int unsigned WIDTH = 1
) (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] meta_q;

   // reset to all ones: an idle two-wire bus and a released pin read high
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta_q <= '1;
         sync_o <= '1;
      end else if (ce_i) begin
         meta_q <= async_i;
         sync_o <= meta_q;
      end
   end
endmodule
`default_nettype wire
